/* rtl/brm_cfg.svh */
// What this block does
// - Sixteen track buses form the destination side; any channel may feed any bus.
// - In select mode, key presses create or remove crosspoints to selected items.
// - A bus key pressed in idle selects that bus and flashes its indicator.
// - With a bus selected, a channel key routes that channel; channel indicator bright.
// - Pressing the flashing bus key again returns to idle, indicators dim.
// - In idle a dim indicator means an existing crosspoint on that item.
// - Two channel keys together act on the whole inclusive channel range.
// - Two bus keys together in idle select the inclusive bus range, all flashing.
// - With buses selected, a channel range press routes all those channels to them.
// - Pressing the same range selection again returns to idle.
// - The clear modifier key pressed in select mode escapes to idle.
// - Channel key in idle lights its buses bright; pressing again leaves select.
// - Bus key in idle lights bright every channel feeding that bus.
// - Clear modifier held: next channel or bus press clears all its crosspoints.
// - Clear modifier also works on ranges, e.g. buses 1 to 16 clear everything.
// - Indicators: off none, flashing selected, bright counterpart, dim crosspoint.
// - After the hold, range indicators blink faster, then one-to-one routes are made.
// - Incremental routing replaces existing crosspoints of the range's channels.
// - Default mapping routes each channel to the bus of the same number.
// - Alternative mapping routes the lowest channel to bus one, then upward.
// - Short press latches a routing key, a long press makes it momentary.
`ifndef BRM_CFG_SVH
`define BRM_CFG_SVH

`define BRM_NUM_BUS 16
`define BRM_NUM_CH 32
`define BRM_CLK_HZ 50000000
`define BRM_MS_CYC(ms) ((ms) * (`BRM_CLK_HZ / 1000))
// Times in milliseconds
`define BRM_SIM_WIN_MS 20
`define BRM_LONG_PRESS_MS 500
`define BRM_INC_HOLD_MS 3000
`define BRM_INC_SHOW_MS 500
`define BRM_BLINK_MS 250
`define BRM_FAST_BLINK_MS 60
// Register byte offsets
`define BRM_REG_CTRL 4'h0
`define BRM_REG_STATUS 4'h4
`define BRM_REG_CHIDX 4'h8
`define BRM_REG_XPDATA 4'hc
// Field positions
`define BRM_CTRL_ALT_BIT 0
`define BRM_STAT_CLR_BIT 2
`define BRM_STAT_ANY_BIT 3
`define BRM_CTRL_RESET 1'b0

`endif

/* rtl/brm_pkg.sv */
package brm_pkg;
   // Gray order along idle -> channel select -> incremental
   typedef enum logic [1:0] {
      BRM_IDLE = 2'b00,
      BRM_CHSEL = 2'b01,
      BRM_INC = 2'b11,
      BRM_BUSSEL = 2'b10
   } brm_state_t;

   typedef enum logic [1:0] {
      BRM_OP_NONE = 2'b00,
      BRM_OP_TOGGLE = 2'b01,
      BRM_OP_CLR = 2'b10,
      BRM_OP_INC = 2'b11
   } brm_op_t;
endpackage

/* rtl/brm_key_group.sv */
`timescale 1ns/1ps
`default_nettype none
module brm_key_group #(
   parameter int N = 32,
   parameter int IW = 5,
   parameter int WIN_CYC = 1000000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Raw keys
   input wire logic [N-1:0] keys,
   // Decoded command
   output logic cmdValid,
   output logic [IW-1:0] cmdLo,
   output logic [IW-1:0] cmdHi,
   output logic held,
   output logic [31:0] holdCyc,
   output logic released
);
   logic armedReg, winReg;
   logic [31:0] winCntReg;
   logic [N-1:0] seenReg;
   wire logic [N-1:0] seenAll = seenReg | keys;
   wire logic winDone = winReg && (winCntReg == 32'(WIN_CYC - 1));
   logic [IW-1:0] lo, hi;

   // Every key seen during the window joins one press, lowest and highest bound it
   always_comb begin
      lo = '0;
      hi = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (seenAll[i]) lo = IW'(i);
      end
      for (int i = 0; i < N; i++) begin
         if (seenAll[i]) hi = IW'(i);
      end
   end

   assign held = !armedReg && !winReg && (|keys);

   always_ff @(posedge clock) begin
      if (srst) begin
         armedReg <= 1'b1;
         winReg <= 1'b0;
         winCntReg <= '0;
         seenReg <= '0;
         cmdValid <= 1'b0;
         cmdLo <= '0;
         cmdHi <= '0;
         holdCyc <= '0;
         released <= 1'b0;
      end else begin
         cmdValid <= winDone;
         released <= 1'b0;
         if (armedReg && !winReg && (|keys)) begin
            winReg <= 1'b1;
            winCntReg <= '0;
            seenReg <= keys;
         end else if (winReg) begin
            seenReg <= seenAll;
            winCntReg <= winCntReg + 32'h00000001;
            if (winDone) begin
               winReg <= 1'b0;
               armedReg <= 1'b0;
               cmdLo <= lo;
               cmdHi <= hi;
               holdCyc <= '0;
            end
         end else if (!armedReg) begin
            // No new press until every key is up, so a held range cannot retrigger
            if (|keys) begin
               if (holdCyc != 32'hffffffff) holdCyc <= holdCyc + 32'h00000001;
            end else begin
               armedReg <= 1'b1;
               released <= 1'b1;
            end
         end
      end
   end
endmodule // brm_key_group
`default_nettype wire

/* rtl/brm_matrix.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brm_cfg.svh"
module brm_matrix #(
   parameter int NUM_CH = `BRM_NUM_CH,
   parameter int NUM_BUS = `BRM_NUM_BUS,
   parameter int SIM_WIN_CYC = `BRM_MS_CYC(`BRM_SIM_WIN_MS),
   parameter int LONG_CYC = `BRM_MS_CYC(`BRM_LONG_PRESS_MS),
   parameter int INC_HOLD_CYC = `BRM_MS_CYC(`BRM_INC_HOLD_MS),
   parameter int INC_SHOW_CYC = `BRM_MS_CYC(`BRM_INC_SHOW_MS),
   parameter int BLINK_CYC = `BRM_MS_CYC(`BRM_BLINK_MS),
   parameter int FAST_CYC = `BRM_MS_CYC(`BRM_FAST_BLINK_MS)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Panel keys
   input wire logic [NUM_CH-1:0] chanKey,
   input wire logic [NUM_BUS-1:0] busKey,
   input wire logic clearKey,
   // Indicators
   output logic [NUM_CH-1:0] chanLedOn,
   output logic [NUM_CH-1:0] chanLedDim,
   output logic [NUM_BUS-1:0] busLedOn,
   output logic [NUM_BUS-1:0] busLedDim,
   output brm_pkg::brm_state_t routeState,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import brm_pkg::*;

   localparam int CW = $clog2(NUM_CH);
   localparam int BW = $clog2(NUM_BUS);

   // Crosspoint store: one bus mask per channel
   logic [NUM_BUS-1:0] xpReg [NUM_CH];
   brm_state_t stateReg, stateNext;
   logic [NUM_CH-1:0] selChReg, selChNext;
   logic [NUM_BUS-1:0] selBusReg, selBusNext, busRouted, selFeed;
   logic clearPrevReg, clearArmedReg, clearUsed;
   logic altMapReg;
   logic [CW-1:0] chIdxReg, incBaseReg;
   logic [31:0] incCntReg, blinkCntReg, fastCntReg;
   logic slowPhaseReg, fastPhaseReg;
   brm_op_t opKind;
   logic [NUM_CH-1:0] opCh;
   logic [NUM_BUS-1:0] opBus;
   logic covered;
   logic [NUM_BUS-1:0] incMask [NUM_CH];

   // Key decoding
   logic chCmd, chRel, chHeld, busCmd, busRel, busHeld;
   logic [CW-1:0] chLo, chHi;
   logic [BW-1:0] busLo, busHi;
   logic [31:0] chHold, busHold;

   brm_key_group #(.N(NUM_CH), .IW(CW), .WIN_CYC(SIM_WIN_CYC)) chanGroup (
      .clock(clock),
      .srst(srst),
      .keys(chanKey),
      .cmdValid(chCmd),
      .cmdLo(chLo),
      .cmdHi(chHi),
      .held(chHeld),
      .holdCyc(chHold),
      .released(chRel)
   );

   brm_key_group #(.N(NUM_BUS), .IW(BW), .WIN_CYC(SIM_WIN_CYC)) busGroup (
      .clock(clock),
      .srst(srst),
      .keys(busKey),
      .cmdValid(busCmd),
      .cmdLo(busLo),
      .cmdHi(busHi),
      .held(busHeld),
      .holdCyc(busHold),
      .released(busRel)
   );

   logic [NUM_CH-1:0] chRange;
   logic [NUM_BUS-1:0] busRange;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         chRange[i] = (i >= int'(chLo)) && (i <= int'(chHi));
      end
      for (int j = 0; j < NUM_BUS; j++) begin
         busRange[j] = (j >= int'(busLo)) && (j <= int'(busHi));
      end
   end

   wire logic clearRise = clearKey && !clearPrevReg;
   wire logic clearMod = clearKey && clearArmedReg;
   wire logic chLong = chRel && (chHold >= 32'(LONG_CYC));
   wire logic busLong = busRel && (busHold >= 32'(LONG_CYC));
   wire logic incStart = chHeld && (chLo != chHi) && (chHold == 32'(INC_HOLD_CYC));
   wire logic incDone = incCntReg == 32'(INC_SHOW_CYC - 1);

   always_comb begin
      stateNext = stateReg;
      selChNext = selChReg;
      selBusNext = selBusReg;
      opKind = BRM_OP_NONE;
      opCh = '0;
      opBus = '0;
      clearUsed = 1'b0;
      case (stateReg)
         BRM_IDLE: begin
            if (chCmd && clearMod) begin
               opKind = BRM_OP_CLR;
               opCh = chRange;
               opBus = '1;
               clearUsed = 1'b1;
            end else if (busCmd && clearMod) begin
               opKind = BRM_OP_CLR;
               opCh = '1;
               opBus = busRange;
               clearUsed = 1'b1;
            end else if (chCmd) begin
               stateNext = BRM_CHSEL;
               selChNext = chRange;
            end else if (busCmd) begin
               stateNext = BRM_BUSSEL;
               selBusNext = busRange;
            end
         end
         BRM_CHSEL: begin
            // Long hold released means the key was used momentarily
            if (clearRise || (chCmd && chRange == selChReg) || chLong) begin
               stateNext = BRM_IDLE;
               selChNext = '0;
            end else if (chCmd) begin
               selChNext = chRange;
            end else if (incStart) begin
               stateNext = BRM_INC;
            end else if (busCmd) begin
               opKind = BRM_OP_TOGGLE;
               opCh = selChReg;
               opBus = busRange;
            end
         end
         BRM_BUSSEL: begin
            if (clearRise || (busCmd && busRange == selBusReg) || busLong) begin
               stateNext = BRM_IDLE;
               selBusNext = '0;
            end else if (busCmd) begin
               selBusNext = busRange;
            end else if (chCmd) begin
               opKind = BRM_OP_TOGGLE;
               opCh = chRange;
               opBus = selBusReg;
            end
         end
         BRM_INC: begin
            if (incDone) begin
               opKind = BRM_OP_INC;
               opCh = selChReg;
               opBus = '1;
               stateNext = BRM_IDLE;
               selChNext = '0;
            end
         end
         default: begin
            stateNext = BRM_IDLE;
         end
      endcase
   end

   // A toggle removes only when every addressed crosspoint already exists
   always_comb begin
      covered = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
         if (opCh[c] && ((xpReg[c] & opBus) != opBus)) covered = 1'b0;
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         int idx;
         idx = altMapReg ? (c - int'(incBaseReg)) : c;
         incMask[c] = (idx >= 0 && idx < NUM_BUS) ?
            ({{(NUM_BUS-1){1'b0}}, 1'b1} << idx) : '0;
      end
   end

   // Wishbone decode; ack comes one cycle after the request and lasts one cycle
   wire logic wbReq = wb_cyc_i && wb_stb_i;
   wire logic wbWr = wbReq && wb_we_i && wb_ack_o;
   wire logic ctrlWr = wbWr && (wb_adr_i == `BRM_REG_CTRL) && wb_sel_i[0];
   wire logic idxWr = wbWr && (wb_adr_i == `BRM_REG_CHIDX) && wb_sel_i[0];
   wire logic xpWr = wbWr && (wb_adr_i == `BRM_REG_XPDATA) && (&wb_sel_i[1:0]);
   wire logic anyRouted = |busRouted;
   wire logic [31:0] statusWord = {28'h0000000, anyRouted, clearKey, stateReg};
   wire logic [31:0] rdData =
      (wb_adr_i == `BRM_REG_CTRL) ? {31'h00000000, altMapReg} :
      (wb_adr_i == `BRM_REG_STATUS) ? statusWord :
      (wb_adr_i == `BRM_REG_CHIDX) ? 32'(chIdxReg) :
      (wb_adr_i == `BRM_REG_XPDATA) ? 32'(xpReg[chIdxReg]) : 32'h00000000;

   always_ff @(posedge clock) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         altMapReg <= `BRM_CTRL_RESET;
         chIdxReg <= '0;
      end else begin
         wb_ack_o <= wbReq && !wb_ack_o;
         if (wbReq && !wb_ack_o) wb_dat_o <= rdData;
         if (ctrlWr) altMapReg <= wb_dat_i[`BRM_CTRL_ALT_BIT];
         if (idxWr) chIdxReg <= wb_dat_i[CW-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         stateReg <= BRM_IDLE;
         selChReg <= '0;
         selBusReg <= '0;
         clearPrevReg <= 1'b0;
         clearArmedReg <= 1'b0;
         incBaseReg <= '0;
         incCntReg <= '0;
      end else begin
         stateReg <= stateNext;
         selChReg <= selChNext;
         selBusReg <= selBusNext;
         clearPrevReg <= clearKey;
         // One clear per hold of the modifier
         if (!clearKey || clearUsed) clearArmedReg <= 1'b0;
         else if (clearRise && stateReg == BRM_IDLE) clearArmedReg <= 1'b1;
         if (incStart) incBaseReg <= chLo;
         incCntReg <= (stateReg == BRM_INC) ? incCntReg + 32'h00000001 : '0;
      end
   end

   // Software writes to the selected channel win over a panel operation in that cycle
   always_ff @(posedge clock) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (srst) begin
            xpReg[c] <= '0;
         end else if (xpWr && c == int'(chIdxReg)) begin
            xpReg[c] <= wb_dat_i[NUM_BUS-1:0];
         end else if (opCh[c]) begin
            case (opKind)
               BRM_OP_TOGGLE: xpReg[c] <= covered ? (xpReg[c] & ~opBus) : (xpReg[c] | opBus);
               BRM_OP_CLR: xpReg[c] <= xpReg[c] & ~opBus;
               BRM_OP_INC: xpReg[c] <= incMask[c];
               default: xpReg[c] <= xpReg[c];
            endcase
         end
      end
   end

   // Blink dividers give one-cycle ticks that flip the phases
   wire logic slowTick = blinkCntReg == 32'(BLINK_CYC - 1);
   wire logic fastTick = fastCntReg == 32'(FAST_CYC - 1);
   always_ff @(posedge clock) begin
      if (srst) begin
         blinkCntReg <= '0;
         fastCntReg <= '0;
         slowPhaseReg <= 1'b0;
         fastPhaseReg <= 1'b0;
      end else begin
         blinkCntReg <= slowTick ? '0 : blinkCntReg + 32'h00000001;
         fastCntReg <= fastTick ? '0 : fastCntReg + 32'h00000001;
         if (slowTick) slowPhaseReg <= !slowPhaseReg;
         if (fastTick) fastPhaseReg <= !fastPhaseReg;
      end
   end

   logic [NUM_CH-1:0] chOnNext, chDimNext;
   logic [NUM_BUS-1:0] busOnNext, busDimNext;
   always_comb begin
      busRouted = '0;
      selFeed = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         busRouted = busRouted | xpReg[c];
         if (selChReg[c]) selFeed = selFeed | xpReg[c];
      end
   end

   // Priority: flashing, then bright, then dim, else off
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (selChReg[c] && stateReg == BRM_INC) begin
            chOnNext[c] = fastPhaseReg;
            chDimNext[c] = 1'b0;
         end else if (selChReg[c] && stateReg == BRM_CHSEL) begin
            chOnNext[c] = slowPhaseReg;
            chDimNext[c] = 1'b0;
         end else if (stateReg == BRM_BUSSEL && |(xpReg[c] & selBusReg)) begin
            chOnNext[c] = 1'b1;
            chDimNext[c] = 1'b0;
         end else begin
            chOnNext[c] = |xpReg[c];
            chDimNext[c] = |xpReg[c];
         end
      end
      for (int j = 0; j < NUM_BUS; j++) begin
         if (selBusReg[j] && stateReg == BRM_BUSSEL) begin
            busOnNext[j] = slowPhaseReg;
            busDimNext[j] = 1'b0;
         end else if (stateReg == BRM_CHSEL && selFeed[j]) begin
            busOnNext[j] = 1'b1;
            busDimNext[j] = 1'b0;
         end else begin
            busOnNext[j] = busRouted[j];
            busDimNext[j] = busRouted[j];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         chanLedOn <= '0;
         chanLedDim <= '0;
         busLedOn <= '0;
         busLedDim <= '0;
      end else begin
         chanLedOn <= chOnNext;
         chanLedDim <= chDimNext;
         busLedOn <= busOnNext;
         busLedDim <= busDimNext;
      end
   end

   assign routeState = stateReg;
endmodule // brm_matrix
`default_nettype wire

/* verification/brm_matrix_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module brm_matrix_checker #(
   parameter int NUM_CH = 32,
   parameter int NUM_BUS = 16,
   parameter int SIM_WIN_CYC = 4,
   parameter int INC_HOLD_CYC = 100
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Keys
   input wire logic [NUM_CH-1:0] chanKey,
   input wire logic [NUM_BUS-1:0] busKey,
   input wire logic clearKey,
   // Indicators and state
   input wire logic [NUM_CH-1:0] chanLedOn,
   input wire logic [NUM_CH-1:0] chanLedDim,
   input wire logic [NUM_BUS-1:0] busLedOn,
   input wire logic [NUM_BUS-1:0] busLedDim,
   input wire brm_pkg::brm_state_t routeState,
   // Bus handshake
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   import brm_pkg::*;
   // Window, command cycle, then the state edge
   localparam int SEL_LAT = SIM_WIN_CYC + 2;
   // Slack in case the hold count starts at the first key edge
   localparam int HOLD_LO = INC_HOLD_CYC - SIM_WIN_CYC - 4;
   logic [31:0] selCnt_reg, selCnt_next;
   assign selCnt_next = (routeState == BRM_CHSEL) ? selCnt_reg + 32'h1 : 32'h0;
   always_ff @(posedge clock) begin
      if (srst)
         selCnt_reg <= 32'h0;
      else
         selCnt_reg <= selCnt_next;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   chk_dim_needs_on: assert property (
      (chanLedDim & ~chanLedOn) == '0 && (busLedDim & ~busLedOn) == '0)
      else $error("dim indicator without on");
   chk_idle_all_dim: assert property (
      $past(routeState) == BRM_IDLE && routeState == BRM_IDLE |->
      chanLedOn == chanLedDim && busLedOn == busLedDim)
      else $error("lit indicator in idle is not dim");
   chk_bus_select: assert property (
      routeState == BRM_IDLE && !clearKey && busKey != '0 && $past(busKey) == '0 &&
      chanKey == '0 && $past(chanKey) == '0 |-> ##SEL_LAT routeState == BRM_BUSSEL)
      else $error("bus press did not select");
   chk_chan_select: assert property (
      routeState == BRM_IDLE && !clearKey && chanKey != '0 && $past(chanKey) == '0 &&
      busKey == '0 && $past(busKey) == '0 |-> ##SEL_LAT routeState == BRM_CHSEL)
      else $error("channel press did not select");
   chk_clear_escape: assert property (
      (routeState == BRM_BUSSEL || routeState == BRM_CHSEL) && $rose(clearKey) |->
      ##[1:4] routeState == BRM_IDLE)
      else $error("clear modifier did not escape");
   chk_inc_entry: assert property (
      $rose(routeState == BRM_INC) |->
      $past(routeState) == BRM_CHSEL && $countones($past(chanKey)) >= 2)
      else $error("incremental entered from wrong state");
   chk_inc_hold: assert property (
      $rose(routeState == BRM_INC) |-> selCnt_reg >= HOLD_LO)
      else $error("incremental entered before hold time");
   chk_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus request not answered in one cycle");
endmodule // brm_matrix_checker

bind brm_matrix brm_matrix_checker #(
   .NUM_CH(NUM_CH),
   .NUM_BUS(NUM_BUS),
   .SIM_WIN_CYC(SIM_WIN_CYC),
   .INC_HOLD_CYC(INC_HOLD_CYC)
) u_chk (.clock(clock), .srst(srst), .chanKey(chanKey), .busKey(busKey),
   .clearKey(clearKey), .chanLedOn(chanLedOn), .chanLedDim(chanLedDim),
   .busLedOn(busLedOn), .busLedDim(busLedDim), .routeState(routeState),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* verification/brm_operator.sv */
`timescale 1ns/1ps
`default_nettype none
module brm_operator #(
   parameter int NUM_CH = 32,
   parameter int NUM_BUS = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Press request
   input wire logic req,
   input wire logic [NUM_CH-1:0] reqChan,
   input wire logic [NUM_BUS-1:0] reqBus,
   input wire logic [15:0] reqHold,
   output logic busy,
   // Panel switches
   output logic [NUM_CH-1:0] chanKey,
   output logic [NUM_BUS-1:0] busKey
);
   // All keys up for a few cycles so the next press opens a fresh window
   localparam logic [15:0] GAP = 16'h3;
   logic [15:0] cnt_reg;
   always_ff @(posedge clock) begin
      if (srst) begin
         busy <= 1'b0;
         cnt_reg <= 16'h0;
         chanKey <= '0;
         busKey <= '0;
      end else if (!busy && req) begin
         chanKey <= reqChan;
         busKey <= reqBus;
         cnt_reg <= reqHold + GAP;
         busy <= 1'b1;
      end else if (busy) begin
         cnt_reg <= cnt_reg - 16'h1;
         if (cnt_reg == GAP) begin
            chanKey <= '0;
            busKey <= '0;
         end
         if (cnt_reg == 16'h0)
            busy <= 1'b0;
      end
   end
endmodule // brm_operator
`default_nettype wire

/* verification/brm_matrix_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module brm_matrix_tb;
   import brm_pkg::*;
   localparam int W = 4;
   localparam int LONG = 40;
   localparam int HOLD = 100;
   localparam int BLINK = 8;
   logic clock, srst, clearKey, req, busy, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [31:0] chanKey, reqChan, chanLedOn, chanLedDim, wb_dat_i, wb_dat_o, rdat, m;
   logic [15:0] busKey, reqBus, busLedOn, busLedDim, reqHold, ends;
   logic [3:0] wb_adr_i, wb_sel_i;
   brm_state_t routeState;
   logic [15:0] xp [32];
   int badCount, checks, b, c, lo, hi, n;
   brm_matrix #(.SIM_WIN_CYC(W), .LONG_CYC(LONG), .INC_HOLD_CYC(HOLD), .INC_SHOW_CYC(20),
      .BLINK_CYC(BLINK), .FAST_CYC(3)) dut (.clock(clock), .srst(srst),
      .chanKey(chanKey), .busKey(busKey), .clearKey(clearKey), .chanLedOn(chanLedOn),
      .chanLedDim(chanLedDim), .busLedOn(busLedOn), .busLedDim(busLedDim),
      .routeState(routeState), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));
   brm_operator op (.clock(clock), .srst(srst), .req(req), .reqChan(reqChan),
      .reqBus(reqBus), .reqHold(reqHold), .busy(busy), .chanKey(chanKey), .busKey(busKey));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic reportAndStop;
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic hang;
      badCount++;
      reportAndStop();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         badCount++;
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
      input logic [31:0] dat);
      int k;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      k = 0;
      do begin @(posedge clock); k++; end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) hang();
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 4'hf, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic chkXp;
      for (int i = 0; i < 32; i++) begin
         wb(1'b1, 4'h8, 4'h1, 32'(i));
         rd(4'hc, {16'h0, xp[i]});
      end
   endtask
   task automatic opStart(input logic [31:0] cm, input logic [15:0] bm, input int hold);
      int k;
      @(posedge clock);
      reqChan <= cm;
      reqBus <= bm;
      reqHold <= 16'(hold);
      req <= 1'b1;
      k = 0;
      do begin @(posedge clock); k++; end while (busy !== 1'b1 && k < 50);
      if (k >= 50) hang();
      req <= 1'b0;
   endtask
   task automatic opWait;
      int k;
      k = 0;
      do begin @(posedge clock); k++; end while (busy !== 1'b0 && k < 1000);
      if (k >= 1000) hang();
      repeat (4) @(posedge clock);
   endtask
   task automatic press(input logic [31:0] cm, input logic [15:0] bm);
      opStart(cm, bm, 8);
      opWait();
   endtask
   task automatic clr(input logic [31:0] cm, input logic [15:0] bm);
      clearKey <= 1'b1;
      repeat (3) @(posedge clock);
      press(cm, bm);
      clearKey <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task automatic st(input brm_state_t s);
      chk({30'h0, routeState}, {30'h0, s});
   endtask
   function automatic logic [31:0] rng(input int a, input int z);
      logic [31:0] r;
      r = '0;
      for (int i = a; i <= z; i++) r[i] = 1'b1;
      return r;
   endfunction
   // Toggle: removes only when every addressed crosspoint already exists
   function automatic void apply(input logic [31:0] cm, input logic [15:0] bm);
      logic all;
      all = 1'b1;
      for (int i = 0; i < 32; i++) if (cm[i] && (xp[i] & bm) != bm) all = 1'b0;
      for (int i = 0; i < 32; i++) if (cm[i]) xp[i] = all ? xp[i] & ~bm : xp[i] | bm;
   endfunction
   function automatic logic [31:0] feeders(input int bb);
      logic [31:0] r;
      for (int i = 0; i < 32; i++) r[i] = xp[i][bb];
      return r;
   endfunction
   initial begin
      {srst, clearKey, req, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h20;
      {reqChan, reqBus, reqHold, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      badCount = 0;
      checks = 0;
      for (int i = 0; i < 32; i++) xp[i] = 16'h0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      n = $urandom(32'h1ff5);
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      chk(chanLedOn | {16'h0, busLedOn}, 32'h0);
      wb(1'b1, 4'h0, 4'h0, 32'h1);
      rd(4'h0, 32'h0);
      wb(1'b1, 4'h6, 4'hf, 32'hff);
      rd(4'h6, 32'h0);
      $display("test registers done");
      for (int t = 0; t < 4; t++) begin
         b = $urandom % 16;
         c = $urandom % 32;
         press(32'h0, 16'h1 << b);
         st(BRM_BUSSEL);
         n = 0;
         repeat (2 * BLINK + 2) begin @(posedge clock); n = n | (busLedOn[b] ? 2 : 1); end
         chk(n, 3);
         press(32'h1 << c, 16'h0);
         apply(32'h1 << c, 16'h1 << b);
         chk({31'h0, chanLedOn[c] & ~chanLedDim[c]}, {31'h0, xp[c][b]});
         press(32'h0, 16'h1 << b);
         st(BRM_IDLE);
         chk({31'h0, busLedDim[b]}, {31'h0, feeders(b) != 0});
         chk({31'h0, chanLedDim[c]}, {31'h0, xp[c] != 0});
      end
      chkXp();
      $display("test single routes done");
      lo = $urandom % 8;
      hi = lo + 1 + $urandom % 8;
      b = $urandom % 8;
      c = b + 1 + $urandom % 7;
      ends = (16'h1 << b) | (16'h1 << c);
      press(32'h0, ends);
      st(BRM_BUSSEL);
      m = 0;
      repeat (2 * BLINK + 2) begin @(posedge clock); m = m | {16'h0, busLedOn}; end
      chk(m & rng(b, c), rng(b, c));
      press((32'h1 << lo) | (32'h1 << hi), 16'h0);
      apply(rng(lo, hi), 16'(rng(b, c)));
      press(32'h0, ends);
      st(BRM_IDLE);
      chkXp();
      press(32'h0, ends);
      clearKey <= 1'b1;
      repeat (4) @(posedge clock);
      st(BRM_IDLE);
      clearKey <= 1'b0;
      $display("test ranges done");
      press(32'h1 << lo, 16'h0);
      st(BRM_CHSEL);
      chk({16'h0, busLedOn & ~busLedDim}, {16'h0, xp[lo]});
      press(32'h1 << lo, 16'h0);
      st(BRM_IDLE);
      press(32'h0, 16'h1 << b);
      chk(chanLedOn & ~chanLedDim, feeders(b));
      press(32'h0, 16'h1 << b);
      $display("test interrogation done");
      clr(32'h1 << lo, 16'h0);
      xp[lo] = 16'h0;
      clr(32'h0, 16'h1 << c);
      for (int i = 0; i < 32; i++) xp[i][c] = 1'b0;
      chkXp();
      clr(32'h0, 16'h8001);
      for (int i = 0; i < 32; i++) xp[i] = 16'h0;
      rd(4'h4, 32'h0);
      chkXp();
      $display("test clearing done");
      for (int alt = 0; alt < 2; alt++) begin
         wb(1'b1, 4'h0, 4'h1, 32'(alt));
         lo = $urandom % 8;
         hi = lo + 1 + $urandom % 7;
         wb(1'b1, 4'h8, 4'h1, 32'(lo));
         wb(1'b1, 4'hc, 4'h3, 32'hffff);
         xp[lo] = 16'hffff;
         rd(4'hc, 32'hffff);
         opStart((32'h1 << lo) | (32'h1 << hi), 16'h0, HOLD + 60);
         n = 0;
         do begin @(posedge clock); n++; end while (routeState !== BRM_INC && n < 2 * HOLD);
         if (n >= 2 * HOLD) hang();
         st(BRM_INC);
         opWait();
         for (int i = lo; i <= hi; i++) xp[i] = (alt == 1) ? 16'h1 << (i - lo) : 16'h1 << i;
         chkXp();
      end
      $display("test incremental done");
      b = $urandom % 16;
      opStart(32'h0, 16'h1 << b, LONG + 10);
      repeat (W + 4) @(posedge clock);
      st(BRM_BUSSEL);
      opWait();
      st(BRM_IDLE);
      $display("test momentary done");
      reportAndStop();
   end
endmodule // brm_matrix_tb
`default_nettype wire
